// >>> pxc_cap_regs.v
// Bridge status, split budget and power capability configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "pxc_defines.vh"

module pxc_cap_regs
(
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire reverse_mode,
	input wire wide_transfer_request_n,
	input wire cfg_valid,
	input wire [3:0] cfg_cmd,
	input wire cfg_idsel,
	input wire [31:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire [3:0] cfg_be,
	input wire [2:0] own_function,
	input wire [7:0] primary_bus_number,
	input wire ev_completion_discarded,
	input wire ev_completion_arrived,
	input wire [15:0] ev_requester_id,
	input wire ev_completion_overrun,
	input wire [15:0] req_size_adq,
	input wire [15:0] up_outstanding_adq,
	input wire [15:0] dn_outstanding_adq,
	input wire up_req_pending,
	input wire dn_req_pending,
	input wire power_event,
	output reg [31:0] cfg_rdata,
	output reg cfg_hit,
	output wire [15:0] completer_id,
	output wire up_req_allow,
	output wire dn_req_allow,
	output wire [1:0] power_state,
	output reg internal_reset,
	output wire power_event_out_n
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [2:0] func_q; // Function number
	reg [4:0] dev_q; // Device number
	reg [7:0] bus_q; // Bus number
	reg wide_q; // Primary wide-capable bit
	reg discard_q; // Discarded completion flag
	reg unexp_q; // Unexpected completion flag
	reg overrun_q; // Completion overrun flag
	reg delayed_q; // Request delayed flag
	reg [15:0] up_limit_q; // Upstream commitment limit
	reg [15:0] dn_limit_q; // Downstream commitment limit
	reg [1:0] pstate_q; // Power state
	reg pme_en_q; // Sticky event enable
	reg pme_st_q; // Sticky event status
	reg [3:0] rst_cnt_q; // Internal reset pulse counter
	reg rst_seen_q; // Reset release seen for strap capture
	reg [2:0] strap_cnt_q; // Waits for the synchroniser to settle
	wire req_wide_sync; // Synchronised wide request level

	// ----------------------------------------
	// Strap input synchroniser
	// ----------------------------------------
	pxc_sync u_wide_sync
	(
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in(wide_transfer_request_n),
		.reset_val(1'b1),
		.sync_out(req_wide_sync)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire addressed; // Transaction is a type 0 access to us
	wire wr_hit; // Write aimed at this bridge
	wire [7:0] reg_off; // Dword offset
	wire [31:0] wmask; // Byte-enable mask
	wire [16:0] up_sum; // Upstream committed plus new, with carry
	wire [16:0] dn_sum; // Downstream committed plus new, with carry
	wire up_room; // Upstream request fits
	wire dn_room; // Downstream request fits
	wire own_req; // Requester ID equals our own

	assign addressed = cfg_valid && cfg_idsel &&
		(cfg_addr[1:0] == `PXC_ADDR_TYPE0) &&
		(cfg_addr[10:8] == own_function);
	assign wr_hit = addressed && (cfg_cmd == `PXC_CMD_CFG_WRITE);
	assign reg_off = {cfg_addr[7:2], 2'h0};
	assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
		{8{cfg_be[1]}}, {8{cfg_be[0]}}};
	assign completer_id = {bus_q, dev_q, func_q};
	assign own_req = (ev_requester_id == completer_id);
	assign up_sum = {1'b0, up_outstanding_adq} + {1'b0, req_size_adq};
	assign dn_sum = {1'b0, dn_outstanding_adq} + {1'b0, req_size_adq};
	// Unlimited setting passes regardless of space; sum kept full width
	assign up_room = (up_limit_q == `PXC_LIMIT_NONE) ||
		(up_sum <= {1'b0, up_limit_q});
	assign dn_room = (dn_limit_q == `PXC_LIMIT_NONE) ||
		(dn_sum <= {1'b0, dn_limit_q});
	assign up_req_allow = up_room;
	assign dn_req_allow = dn_room;
	assign power_state = pstate_q;
	// Event output low only when enabled and pending
	assign power_event_out_n = ~(pme_en_q & pme_st_q);

	// ----------------------------------------
	// Write data seen per field
	// ----------------------------------------
	wire [31:0] w_clr; // Write-one-to-clear bits
	wire [1:0] ps_new; // Power state being written
	wire ps_write; // Power state write valid
	assign w_clr = cfg_wdata & wmask;
	assign ps_new = cfg_wdata[1:0];
	assign ps_write = wr_hit && (reg_off == `PXC_OFF_POWER_CSR) &&
		cfg_be[0] && ((ps_new == `PXC_PS_D0) ||
		(ps_new == `PXC_PS_D3));

	// Identity fields and strap capture
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			func_q <= `PXC_RST_FUNC;
			dev_q <= `PXC_RST_DEV;
			bus_q <= `PXC_RST_BUS;
			wide_q <= 1'b0;
			rst_seen_q <= 1'b0;
			strap_cnt_q <= 3'h0;
		end
		else if (clk_en)
		begin
			// Strap captured once the synchroniser has flushed
			if (!rst_seen_q)
			begin
				if (strap_cnt_q == `PXC_STRAP_WAIT)
				begin
					rst_seen_q <= 1'b1;
					wide_q <= reverse_mode & ~req_wide_sync;
				end
				else
					strap_cnt_q <= strap_cnt_q + 3'h1;
			end
			if (wr_hit)
			begin
				dev_q <= cfg_addr[15:11];
				func_q <= cfg_addr[10:8];
			end
			bus_q <= primary_bus_number;
		end
	end

	// Sticky error flags, set wins over clear
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			discard_q <= 1'b0;
			unexp_q <= 1'b0;
			overrun_q <= 1'b0;
			delayed_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_hit && (reg_off == `PXC_OFF_BRIDGE_STATUS))
			begin
				if (w_clr[`PXC_BIT_DISCARD])
					discard_q <= 1'b0;
				if (w_clr[`PXC_BIT_UNEXP])
					unexp_q <= 1'b0;
				if (w_clr[`PXC_BIT_OVERRUN])
					overrun_q <= 1'b0;
				if (w_clr[`PXC_BIT_DELAYED])
					delayed_q <= 1'b0;
			end
			// Discarded completions tracked in forward mode only
			if (!reverse_mode && ev_completion_discarded)
				discard_q <= 1'b1;
			// Unexpected completion matches our own ID in reverse mode
			if (reverse_mode && ev_completion_arrived && own_req)
				unexp_q <= 1'b1;
			if (ev_completion_overrun)
				overrun_q <= 1'b1;
			if ((up_req_pending && !up_room) ||
				(dn_req_pending && !dn_room))
				delayed_q <= 1'b1;
		end
	end

	// Commitment limits
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			up_limit_q <= `PXC_RST_LIMIT;
			dn_limit_q <= `PXC_RST_LIMIT;
		end
		else if (clk_en && wr_hit)
		begin
			if (reg_off == `PXC_OFF_UP_SPLIT)
				up_limit_q <= (up_limit_q & ~wmask[31:16]) |
					(cfg_wdata[31:16] & wmask[31:16]);
			if (reg_off == `PXC_OFF_DN_SPLIT)
				dn_limit_q <= (dn_limit_q & ~wmask[31:16]) |
					(cfg_wdata[31:16] & wmask[31:16]);
		end
	end

	// Power state and internal reset sequencing
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			pstate_q <= `PXC_PS_D0;
			rst_cnt_q <= 4'h0;
			internal_reset <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ps_write)
			begin
				pstate_q <= ps_new;
				if ((pstate_q == `PXC_PS_D3) && (ps_new == `PXC_PS_D0))
					rst_cnt_q <= `PXC_RESET_PULSE;
			end
			else if (rst_cnt_q != 4'h0)
				rst_cnt_q <= rst_cnt_q - 4'h1;
			// Internal reset only; bus reset pin untouched
			internal_reset <= (rst_cnt_q != 4'h0);
		end
	end

	// Sticky power-event bits survive internal reset
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			pme_en_q <= 1'b0;
			pme_st_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_hit && (reg_off == `PXC_OFF_POWER_CSR) && cfg_be[1])
			begin
				pme_en_q <= cfg_wdata[`PXC_BIT_PME_EN];
				if (cfg_wdata[`PXC_BIT_PME_ST])
					pme_st_q <= 1'b0;
			end
			if (power_event)
				pme_st_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Read data registered, hit flags an addressed read
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			cfg_rdata <= 32'h0;
			cfg_hit <= 1'b0;
		end
		else if (clk_en)
		begin
			cfg_hit <= addressed && (cfg_cmd == `PXC_CMD_CFG_READ);
			case (reg_off)
				`PXC_OFF_BRIDGE_STATUS:
					cfg_rdata <= {10'h0, delayed_q, overrun_q,
						unexp_q & reverse_mode,
						discard_q & ~reverse_mode,
						reverse_mode,
						wide_q, bus_q, dev_q, func_q};
				`PXC_OFF_UP_SPLIT:
					cfg_rdata <= {up_limit_q, `PXC_SPLIT_CAP};
				`PXC_OFF_DN_SPLIT:
					cfg_rdata <= {dn_limit_q, `PXC_SPLIT_CAP};
				`PXC_OFF_POWER_CAP:
					cfg_rdata <= {`PXC_PM_EVT_SUP, 2'h0, `PXC_PM_AUX,
						2'h0, 1'b0, `PXC_PM_VERSION,
						`PXC_PM_NEXT, `PXC_PM_CAP_ID};
				`PXC_OFF_POWER_CSR:
					cfg_rdata <= {16'h0, pme_st_q, 6'h0, pme_en_q,
						6'h0, pstate_q};
				`PXC_OFF_SLOT_IDENT:
					cfg_rdata <= {24'h0, `PXC_SLOT_CAP_ID};
				default:
					cfg_rdata <= 32'h0;
			endcase
		end
	end

endmodule // pxc_cap_regs

`default_nettype wire

// >>> pxc_cap_regs_chk.sv
// Port checker for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module pxc_chk
(
	input wire clk,
	input wire reset_n,
	input wire cfg_valid,
	input wire [3:0] cfg_cmd,
	input wire cfg_idsel,
	input wire [31:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire [2:0] own_function,
	input wire cfg_hit,
	input wire [15:0] completer_id,
	input wire [1:0] power_state,
	input wire internal_reset
);
	// Addressed type 0 request decode
	wire sel = cfg_valid && cfg_idsel && cfg_addr[1:0] == 2'h0 &&
		cfg_addr[10:8] == own_function;
	wire wr = sel && cfg_cmd == 4'hb;
	wire psw = wr && cfg_addr[7:0] == 8'h94;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_read_hit: assert property (sel && cfg_cmd == 4'ha |=> cfg_hit)
		else $error("read not answered");
	a_hit_cause: assert property (cfg_hit |-> $past(cfg_valid) &&
		$past(cfg_cmd) == 4'ha) else $error("stray hit");
	a_dev_latch: assert property (wr |=>
		completer_id[7:3] == $past(cfg_addr[15:11])) else $error("dev");
	a_func_latch: assert property (wr |=>
		completer_id[2:0] == $past(cfg_addr[10:8])) else $error("func");
	a_ps_ignore: assert property (psw && (cfg_wdata[0] ^ cfg_wdata[1])
		|=> $stable(power_state)) else $error("bad state taken");
	a_ps_write: assert property (psw && cfg_wdata[1:0] == 2'h3
		|=> power_state == 2'h3) else $error("D3 not taken");
	a_rst_cause: assert property (power_state == 2'h0 &&
		$past(power_state) == 2'h3 |-> ##[0:2] internal_reset)
		else $error("no internal reset");
	a_rst_len: assert property ($rose(internal_reset) |->
		internal_reset [*4] ##1 !internal_reset) else $error("pulse");
	cover property (wr);
	cover property (psw && cfg_wdata[1:0] == 2'h3);
	cover property ($rose(internal_reset));
endmodule // pxc_chk
bind pxc_cap_regs pxc_chk u_chk (.clk(clk), .reset_n(reset_n),
	.cfg_valid(cfg_valid), .cfg_cmd(cfg_cmd), .cfg_idsel(cfg_idsel),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .own_function(own_function),
	.cfg_hit(cfg_hit), .completer_id(completer_id),
	.power_state(power_state), .internal_reset(internal_reset));
`default_nettype wire

// >>> pxc_defines.vh
// Offsets, field positions and reset values of the capability register bank
`ifndef PXC_DEFINES_VH
`define PXC_DEFINES_VH

// ----------------------------------------
// Register offsets (dword aligned)
// ----------------------------------------
`define PXC_OFF_BRIDGE_STATUS 8'h84
`define PXC_OFF_UP_SPLIT 8'h88
`define PXC_OFF_DN_SPLIT 8'h8c
`define PXC_OFF_POWER_CAP 8'h90
`define PXC_OFF_POWER_CSR 8'h94
`define PXC_OFF_SLOT_IDENT 8'ha0

// ----------------------------------------
// Configuration bus encodings
// ----------------------------------------
`define PXC_CMD_CFG_READ 4'ha
`define PXC_CMD_CFG_WRITE 4'hb
`define PXC_ADDR_TYPE0 2'h0

// ----------------------------------------
// Status field positions and resets
// ----------------------------------------
`define PXC_BIT_WIDE 16
`define PXC_BIT_FAST 17
`define PXC_BIT_DISCARD 18
`define PXC_BIT_UNEXP 19
`define PXC_BIT_OVERRUN 20
`define PXC_BIT_DELAYED 21
`define PXC_RST_FUNC 3'h0
`define PXC_RST_DEV 5'h1f
`define PXC_RST_BUS 8'hff

// ----------------------------------------
// Split budget values
// ----------------------------------------
`define PXC_SPLIT_CAP 16'h0010
`define PXC_RST_LIMIT 16'h0010
`define PXC_LIMIT_NONE 16'hffff

// ----------------------------------------
// Power management constants
// ----------------------------------------
`define PXC_PM_CAP_ID 8'h01
`define PXC_PM_NEXT 8'ha8
`define PXC_PM_VERSION 3'h2
`define PXC_PM_AUX 3'h1
`define PXC_PM_EVT_SUP 5'h19
`define PXC_PS_D0 2'h0
`define PXC_PS_D3 2'h3
`define PXC_BIT_PME_EN 8
`define PXC_BIT_PME_ST 15
`define PXC_SLOT_CAP_ID 8'h04
`define PXC_RESET_PULSE 4'h4
// Enabled cycles after reset before the strap level is trusted
`define PXC_STRAP_WAIT 3'h4

`endif

// >>> pxc_host.sv
// Configuration host issuing single-cycle requests
`timescale 1ns/1ns
`default_nettype none
module pxc_host
(
	input wire logic clk,
	output logic cfg_valid,
	output logic [3:0] cfg_cmd,
	output logic cfg_idsel,
	output logic [31:0] cfg_addr,
	output logic [31:0] cfg_wdata
);
	initial
	begin
		cfg_valid = 1'b0;
		cfg_cmd = 4'h0;
		cfg_idsel = 1'b0;
		cfg_addr = 32'h0;
		cfg_wdata = 32'h0;
	end
	// One request, held across one sampling edge
	task xfer(input logic [3:0] c, input logic s, input logic [31:0] a,
		input logic [31:0] d);
		@(negedge clk);
		cfg_valid = 1'b1;
		cfg_cmd = c;
		cfg_idsel = s;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_valid = 1'b0;
		cfg_idsel = 1'b0;
		// Released lines must not keep the old value
		cfg_addr = ~a;
		cfg_wdata = ~d;
	endtask
endmodule // pxc_host
`default_nettype wire

// >>> pxc_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pxc_sync
(
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire async_in,
	input wire reset_val,
	output reg sync_out
);

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	reg s1_q; // First stage, read only by s2
	reg s2_q; // Second stage
	reg s3_q; // Third stage

	// Shift and accept a level once stages two and three agree
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			// Stages start at the idle level so no false change follows
			s1_q <= reset_val;
			s2_q <= reset_val;
			s3_q <= reset_val;
			sync_out <= reset_val;
		end
		else if (clk_en)
		begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				sync_out <= s3_q;
		end
	end

endmodule // pxc_sync

`default_nettype wire

// >>> test_pxc_cap_regs.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module test_pxc_cap_regs;
	logic clk, reset_n, rev, wide_n, ev_dis, ev_arr, ev_ovr, up_p, dn_p, pev;
	logic [15:0] rid, rsz, up_o, dn_o, cid;
	logic [31:0] rdata, wdata, addr;
	logic [3:0] cmd;
	logic valid, idsel, hit, irst, pme_n, up_a, dn_a;
	logic [1:0] ps;
	logic [7:0] seq = 8'h2d;
	logic [7:0] pexp = 8'h3c;
	int failures = 0;
	int n_checks = 0;
	pxc_host host (.clk(clk), .cfg_valid(valid), .cfg_cmd(cmd),
		.cfg_idsel(idsel), .cfg_addr(addr), .cfg_wdata(wdata));
	pxc_cap_regs dut
	(
		.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .reverse_mode(rev),
		.wide_transfer_request_n(wide_n), .cfg_valid(valid), .cfg_cmd(cmd),
		.cfg_idsel(idsel), .cfg_addr(addr), .cfg_wdata(wdata),
		.cfg_be(4'hf), .own_function(3'h5), .primary_bus_number(8'h3c),
		.ev_completion_discarded(ev_dis), .ev_completion_arrived(ev_arr),
		.ev_requester_id(rid), .ev_completion_overrun(ev_ovr),
		.req_size_adq(rsz), .up_outstanding_adq(up_o),
		.dn_outstanding_adq(dn_o), .up_req_pending(up_p),
		.dn_req_pending(dn_p), .power_event(pev), .cfg_rdata(rdata),
		.cfg_hit(hit), .completer_id(cid), .up_req_allow(up_a),
		.dn_req_allow(dn_a), .power_state(ps), .internal_reset(irst),
		.power_event_out_n(pme_n)
	);
	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Addressed write with a chosen device number
	task wr(input logic [4:0] d, input logic [7:0] o, input logic [31:0] v);
		host.xfer(4'hb, 1'b1, {16'h0, d, 3'h5, o}, v);
	endtask
	// Addressed read, answer taken one cycle later
	task rd(input logic [7:0] o, input logic [31:0] e);
		host.xfer(4'ha, 1'b1, {16'h0, 5'h0, 3'h5, o}, 32'h0);
		chk({31'h0, hit}, 32'h1);
		chk(rdata, e);
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#20000;
		failures++;
		wrap_up;
	end
	initial
	begin
		{reset_n, rev, wide_n, ev_dis, ev_arr, ev_ovr, up_p, dn_p, pev} = 0;
		{rid, rsz, up_o, dn_o} = 0;
		for (int m = 0; m < 2; m++)
		begin
			rev = m[0];
			reset_n = 1'b0;
			repeat (16) @(negedge clk);
			reset_n = 1'b1;
			repeat (8) @(negedge clk);
			rd(8'h84, {14'h0, rev, rev, 8'h3c, 8'hf8});
			rd(8'h88, 32'h00100010);
			rd(8'h8c, 32'h00100010);
			rd(8'h90, 32'hc842a801);
			rd(8'h94, 32'h0);
			rd(8'ha0, 32'h00000004);
			wr(5'h0a, 8'h88, 32'hffff1234);
			rd(8'h88, 32'hffff0010);
			chk({16'h0, cid}, 32'h3c55);
			{rsz, up_o, up_p} = {16'hffff, 16'hffff, 1'b1};
			@(negedge clk);
			chk({31'h0, up_a}, 32'h1);
			{up_p, dn_p, dn_o, rsz} = {1'b0, 1'b1, 16'h000c, 16'h0005};
			@(negedge clk);
			chk({31'h0, dn_a}, 32'h0);
			rsz = 16'h0004;
			@(negedge clk);
			chk({31'h0, dn_a}, 32'h1);
			{dn_p, rid, ev_dis, ev_arr, ev_ovr} = {1'b0, cid, 3'h7};
			@(negedge clk);
			{ev_dis, ev_arr, ev_ovr} = 3'h0;
			rd(8'h84, {10'h0, 2'h3, rev, !rev, rev, rev, 16'h3c55});
			wr(5'h0a, 8'h84, 32'hffffffff);
			rd(8'h84, {14'h0, rev, rev, 16'h3c55});
			for (int k = 0; k < 4; k++)
				host.xfer(k == 0 ? 4'ha : 4'hb, k != 1, {16'h0, 5'h11,
					3'h5 ^ {2'h0, k == 3}, 6'h23, 1'b0, k == 2}, 32'h10000);
			rd(8'h8c, 32'h00100010);
			chk({16'h0, cid}, 32'h3c55);
			for (int k = 0; k < 4; k++)
			begin
				wr(5'h0a, 8'h94, {30'h0, seq[2*k+:2]});
				chk({30'h0, ps}, {30'h0, pexp[2*k+:2]});
			end
			for (int n = 0; n < 4 && irst !== 1'b1; n++)
				@(negedge clk);
			chk({31'h0, irst}, 32'h1);
			repeat (8) @(negedge clk);
			pev = 1'b1;
			@(negedge clk);
			pev = 1'b0;
			rd(8'h94, 32'h8000);
			chk({31'h0, pme_n}, 32'h1);
			wr(5'h0a, 8'h94, 32'h100);
			chk({31'h0, pme_n}, 32'h0);
			wr(5'h0a, 8'h94, 32'h8100);
			rd(8'h94, 32'h100);
			chk({31'h0, pme_n}, 32'h1);
			wr(5'h0a, 8'h94, 32'h0);
		end
		wrap_up;
	end
endmodule // test_pxc_cap_regs
`default_nettype wire
